//--- core/apc_defines.svh
// Purpose: Constants for the gain-control pin, attenuator and power block
// Assumes: 100 MHz mclk_in, 9-bit register addresses, 8-bit registers
// Notes: Included by its bare name
`ifndef APC_DEFINES_SVH
`define APC_DEFINES_SVH
// ======================================================================
// Register map
`define APC_AW 9
`define APC_DW 8
`define APC_ADDR_DEVCFG 9'h002
`define APC_ADDR_STBY_BLK 9'h150
`define APC_ADDR_STBY_PIN 9'h152
`define APC_ADDR_ATT_MODE 9'h180
`define APC_ADDR_ATT_A 9'h181
`define APC_ADDR_ATT_B 9'h182
`define APC_ADDR_ATT_START 9'h183
`define APC_ADDR_ATT_RB 9'h184
`define APC_ADDR_GP_SEL 9'h1b0
`define APC_ADDR_GP_DIR 9'h1b1
`define APC_ADDR_GP_OUT 9'h1b2
`define APC_ADDR_GP_ORB 9'h1b3
`define APC_ADDR_GP_IRB 9'h1b4
// ======================================================================
// Reset values and codes
`define APC_RST_ZERO 8'h00
`define APC_RST_ATT 8'h0c
`define APC_ATT_MIN 8'h00
`define APC_ATT_MAX 8'h1b
`define APC_ATT_STEP 8'h01
`define APC_ALL_ON 8'hff
`define APC_PIN_MASK 8'h0f
// ======================================================================
// Field positions
`define APC_MODE_BIT 0
`define APC_PM_MSB 1
`define APC_PM_LSB 0
`define APC_PM_NORMAL 2'h0
`define APC_PM_SLEEP 2'h1
`define APC_PM_STBY 2'h2
`define APC_SPIN_EN_BIT 0
`define APC_SPIN_SEL_MSB 2
`define APC_SPIN_SEL_LSB 1
`define APC_NVG_BIT 6
`define APC_NPIN 4
`define APC_PIN_INC 0
`define APC_PIN_DEC 1
// ======================================================================
// Timing
`define APC_CLK_NS 10
`define APC_STBY_ENTER_NS 100
`define APC_STBY_ENTER_CYC (`APC_STBY_ENTER_NS / `APC_CLK_NS)
`endif

//--- core/apc_pkg.sv
// Purpose: Types for the gain-control pin, attenuator and power block
// Assumes: One-hot state codes
// Notes: Constants live in apc_defines.svh
package apc_pkg;
  typedef enum logic [2:0] {
    APC_PWR_ON    = 3'b001,
    APC_PWR_STBY  = 3'b010,
    APC_PWR_SLEEP = 3'b100
  } apc_pwr_t;
  typedef enum logic [1:0] {
    APC_ATT_TWO  = 2'b01,
    APC_ATT_STEPS = 2'b10
  } apc_att_mode_t;
endpackage

//--- core/apc_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to mclk_in
// Notes: First stage is read only by the second stage
`timescale 1ns/1ns
module apc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

//--- core/apc_top.sv
// Purpose: Gain-control pins: attenuator modes, GPIO and standby control
// Assumes: Decoded serial-port register access on reg_* ports
// Notes: Pin inputs are synchronised before any use
// Functional notes
// - Bit 0 of attenuator mode register picks two-setting or step mode.
// - Two-setting mode applies one of two programmed values by select pin.
// - Step mode: decrement pulse lowers, increment pulse raises by 1 dB.
// - Step mode starts from the software start-value register.
// - Applied attenuation is readable from a read-only register.
// - Reset gives two-setting mode, both settings at the same default.
// - Per-pin select register hands pins over to GPIO use.
// - Per-pin direction register makes each GPIO an input or output.
// - Output-value register sets level driven on GPIO outputs.
// - Read-only register returns state of GPIO output pins.
// - Read-only register returns sampled level of GPIO input pins.
// - Two-bit power-mode field selects sleep or standby.
// - Standby keeps the serial link and digital clocks running.
// - Pin-control register enables pin standby and names the pin.
// - Standby register picks blocks to power down; clocks, link stay.
// - Bit 6 puts negative voltage generator in standby, slower wake.
// - Low-power state is reached within 100 ns of request.
`timescale 1ns/1ns
`include "apc_defines.svh"
module apc_top
  import apc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [`APC_AW-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [`APC_DW-1:0] reg_wdata_in,
  output logic [`APC_DW-1:0] reg_rdata_out,
  output logic reg_ack_out,
  input wire logic [`APC_NPIN-1:0] gain_control_pins_in,
  output logic [`APC_NPIN-1:0] gain_control_pins_out,
  output logic [`APC_NPIN-1:0] gain_control_pins_oe_n_out,
  output logic [`APC_DW-1:0] atten_code_out,
  output logic sleep_out,
  output logic standby_out,
  output logic [`APC_DW-1:0] block_pd_out,
  output logic clocks_run_out,
  output logic link_run_out,
  output logic neg_voltage_gen_standby_out
);
  localparam int STBY_CYC = `APC_STBY_ENTER_CYC;
  localparam int PIN_INC = `APC_PIN_INC;
  localparam int PIN_DEC = `APC_PIN_DEC;

  logic [`APC_DW-1:0] device_config;
  logic [`APC_DW-1:0] standby_block_select;
  logic [`APC_DW-1:0] standby_pin_control;
  logic [`APC_DW-1:0] attenuator_mode_select;
  logic [`APC_DW-1:0] attenuation_setting_a;
  logic [`APC_DW-1:0] attenuation_setting_b;
  logic [`APC_DW-1:0] attenuation_start_value;
  logic [`APC_DW-1:0] gpio_pin_select;
  logic [`APC_DW-1:0] gpio_direction;
  logic [`APC_DW-1:0] gpio_output_value;
  logic [`APC_DW-1:0] gpio_output_readback;
  logic [`APC_DW-1:0] gpio_input_readback;
  logic [`APC_DW-1:0] atten_code;
  logic [`APC_DW-1:0] next_atten;
  logic [`APC_DW-1:0] read_mux;
  logic [`APC_NPIN-1:0] pins_sync;
  logic [`APC_NPIN-1:0] pins_prev;
  logic [`APC_NPIN-1:0] gp_sel;
  logic [`APC_NPIN-1:0] gp_out_en;
  logic [`APC_NPIN-1:0] stby_pin_mask;
  logic [`APC_NPIN-1:0] agc_free;
  logic [1:0] stby_pin_idx;
  logic [1:0] power_mode_field;
  logic stby_pin_en;
  logic stby_pin_level;
  logic step_req;
  logic atten_select_or_decrement_pin;
  logic atten_increment_pin;
  logic inc_pulse;
  logic dec_pulse;
  apc_att_mode_t att_mode;
  apc_pwr_t pwr_state;
  apc_pwr_t next_pwr;

  // ====================================================================
  // Pin input synchronisation
  apc_sync #(
    .WIDTH(`APC_NPIN)
  ) u_pin_sync (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .async_in(gain_control_pins_in),
    .sync_out(pins_sync)
  );

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pins_prev <= '0;
    end else begin
      pins_prev <= pins_sync;
    end
  end

  // ====================================================================
  // Register writes
  // power-mode write
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      device_config <= `APC_RST_ZERO;
    end else if (reg_wr_in && reg_addr_in == `APC_ADDR_DEVCFG) begin
      device_config <= reg_wdata_in;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      standby_block_select <= `APC_RST_ZERO;
    end else if (reg_wr_in && reg_addr_in == `APC_ADDR_STBY_BLK) begin
      standby_block_select <= reg_wdata_in;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      standby_pin_control <= `APC_RST_ZERO;
    end else if (reg_wr_in && reg_addr_in == `APC_ADDR_STBY_PIN) begin
      standby_pin_control <= reg_wdata_in;
    end
  end

  // reset to two-setting mode, equal defaults
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      attenuator_mode_select <= `APC_RST_ZERO;
      attenuation_setting_a <= `APC_RST_ATT;
      attenuation_setting_b <= `APC_RST_ATT;
      attenuation_start_value <= `APC_RST_ZERO;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `APC_ADDR_ATT_MODE: attenuator_mode_select <= reg_wdata_in;
        `APC_ADDR_ATT_A: attenuation_setting_a <= reg_wdata_in;
        `APC_ADDR_ATT_B: attenuation_setting_b <= reg_wdata_in;
        `APC_ADDR_ATT_START: attenuation_start_value <= reg_wdata_in;
        default: begin
        end
      endcase
    end
  end

  // GPIO select, direction and level registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      gpio_pin_select <= `APC_RST_ZERO;
      gpio_direction <= `APC_RST_ZERO;
      gpio_output_value <= `APC_RST_ZERO;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `APC_ADDR_GP_SEL: gpio_pin_select <= reg_wdata_in & `APC_PIN_MASK;
        `APC_ADDR_GP_DIR: gpio_direction <= reg_wdata_in & `APC_PIN_MASK;
        `APC_ADDR_GP_OUT: gpio_output_value <= reg_wdata_in & `APC_PIN_MASK;
        default: begin
        end
      endcase
    end
  end

  // ====================================================================
  // Pin function routing
  assign gp_sel = gpio_pin_select[`APC_NPIN-1:0];
  assign gp_out_en = gp_sel & gpio_direction[`APC_NPIN-1:0];
  assign stby_pin_en = standby_pin_control[`APC_SPIN_EN_BIT];
  assign stby_pin_idx =
    standby_pin_control[`APC_SPIN_SEL_MSB:`APC_SPIN_SEL_LSB];
  assign stby_pin_mask = stby_pin_en ?
    ({{(`APC_NPIN-1){1'b0}}, 1'b1} << stby_pin_idx) : '0;
  assign agc_free = ~gp_sel & ~stby_pin_mask;
  assign stby_pin_level = stby_pin_en && !gp_sel[stby_pin_idx]
    && pins_sync[stby_pin_idx];

  // GPIO outputs drive the programmed level
  assign gain_control_pins_out = gpio_output_value[`APC_NPIN-1:0];
  assign gain_control_pins_oe_n_out = ~gp_out_en;

  assign gpio_output_readback =
    {{(`APC_DW-`APC_NPIN){1'b0}}, gpio_output_value[`APC_NPIN-1:0] & gp_out_en};
  assign gpio_input_readback =
    {{(`APC_DW-`APC_NPIN){1'b0}}, pins_sync & gp_sel & ~gp_out_en};

  // ====================================================================
  // Attenuator control
  assign step_req = attenuator_mode_select[`APC_MODE_BIT];
  assign atten_select_or_decrement_pin =
    pins_sync[PIN_DEC] && agc_free[PIN_DEC];
  assign atten_increment_pin = pins_sync[PIN_INC] && agc_free[PIN_INC];
  assign dec_pulse = atten_select_or_decrement_pin && !pins_prev[PIN_DEC];
  assign inc_pulse = atten_increment_pin && !pins_prev[PIN_INC];

  // mode bit steers the mode state
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      att_mode <= APC_ATT_TWO;
    end else begin
      att_mode <= step_req ? APC_ATT_STEPS : APC_ATT_TWO;
    end
  end

  always_comb begin
    next_atten = atten_code;
    case (att_mode)
      APC_ATT_TWO: begin
        if (step_req) begin
          next_atten = attenuation_start_value;
        end else if (atten_select_or_decrement_pin) begin
          next_atten = attenuation_setting_b;
        end else begin
          next_atten = attenuation_setting_a;
        end
      end
      APC_ATT_STEPS: begin
        // leaving step mode returns to settings
        if (!step_req) begin
          next_atten = atten_select_or_decrement_pin ?
            attenuation_setting_b : attenuation_setting_a;
        end else if (inc_pulse && !dec_pulse) begin
          if (atten_code < `APC_ATT_MAX) begin
            next_atten = atten_code + `APC_ATT_STEP;
          end
        end else if (dec_pulse && !inc_pulse) begin
          if (atten_code > `APC_ATT_MIN) begin
            next_atten = atten_code - `APC_ATT_STEP;
          end
        end
      end
      default: next_atten = `APC_RST_ATT;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      atten_code <= `APC_RST_ATT;
    end else begin
      atten_code <= next_atten;
    end
  end

  assign atten_code_out = atten_code;

  // ====================================================================
  // Power control
  assign power_mode_field = device_config[`APC_PM_MSB:`APC_PM_LSB];

  always_comb begin
    if (power_mode_field == `APC_PM_SLEEP) begin
      next_pwr = APC_PWR_SLEEP;
    end else if (power_mode_field == `APC_PM_STBY || stby_pin_level) begin
      next_pwr = APC_PWR_STBY;
    end else begin
      next_pwr = APC_PWR_ON;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pwr_state <= APC_PWR_ON;
    end else begin
      pwr_state <= next_pwr;
    end
  end

  // standby powers down selected blocks only
  // one cycle from request to power-down
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      block_pd_out <= `APC_RST_ZERO;
    end else begin
      case (next_pwr)
        APC_PWR_ON: block_pd_out <= `APC_RST_ZERO;
        APC_PWR_STBY: block_pd_out <= standby_block_select;
        APC_PWR_SLEEP: block_pd_out <= `APC_ALL_ON;
        default: block_pd_out <= `APC_RST_ZERO;
      endcase
    end
  end

  assign sleep_out = (pwr_state == APC_PWR_SLEEP);
  assign standby_out = (pwr_state == APC_PWR_STBY);
  // clocks and link stay up in standby
  assign clocks_run_out = (pwr_state != APC_PWR_SLEEP);
  assign link_run_out = (pwr_state != APC_PWR_SLEEP);
  // negative generator standby for slow wake
  assign neg_voltage_gen_standby_out =
    standby_out && block_pd_out[`APC_NVG_BIT];

  // ====================================================================
  // Register reads
  always_comb begin
    case (reg_addr_in)
      `APC_ADDR_DEVCFG: read_mux = device_config;
      `APC_ADDR_STBY_BLK: read_mux = standby_block_select;
      `APC_ADDR_STBY_PIN: read_mux = standby_pin_control;
      `APC_ADDR_ATT_MODE: read_mux = attenuator_mode_select;
      `APC_ADDR_ATT_A: read_mux = attenuation_setting_a;
      `APC_ADDR_ATT_B: read_mux = attenuation_setting_b;
      `APC_ADDR_ATT_START: read_mux = attenuation_start_value;
      `APC_ADDR_ATT_RB: read_mux = atten_code;
      `APC_ADDR_GP_SEL: read_mux = gpio_pin_select;
      `APC_ADDR_GP_DIR: read_mux = gpio_direction;
      `APC_ADDR_GP_OUT: read_mux = gpio_output_value;
      `APC_ADDR_GP_ORB: read_mux = gpio_output_readback;
      `APC_ADDR_GP_IRB: read_mux = gpio_input_readback;
      default: read_mux = `APC_RST_ZERO;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= `APC_RST_ZERO;
      reg_ack_out <= 1'b0;
    end else begin
      reg_ack_out <= reg_rd_in || reg_wr_in;
      if (reg_rd_in) begin
        reg_rdata_out <= read_mux;
      end
    end
  end

  // ====================================================================
  // Assertions
  sequence s_step_entry;
    att_mode == APC_ATT_TWO && step_req;
  endsequence

  sequence s_pin_standby;
    $rose(stby_pin_level) && power_mode_field != `APC_PM_SLEEP;
  endsequence

  property p_mode_follow;
    @(posedge mclk_in) disable iff (rst_in)
    step_req [*2] |-> att_mode == APC_ATT_STEPS;
  endproperty
  a_mode_follow: assert property (p_mode_follow)
    else $error("Mode state does not follow mode bit");

  property p_sel_low;
    @(posedge mclk_in) disable iff (rst_in)
    (!step_req && !atten_select_or_decrement_pin)
    |=> atten_code == $past(attenuation_setting_a);
  endproperty
  a_sel_low: assert property (p_sel_low)
    else $error("Low select did not apply first setting");

  property p_sel_high;
    @(posedge mclk_in) disable iff (rst_in)
    (!step_req && atten_select_or_decrement_pin)
    |=> atten_code == $past(attenuation_setting_b);
  endproperty
  a_sel_high: assert property (p_sel_high)
    else $error("High select did not apply second setting");

  property p_step_up;
    @(posedge mclk_in) disable iff (rst_in)
    (att_mode == APC_ATT_STEPS && step_req && inc_pulse && !dec_pulse
      && atten_code < `APC_ATT_MAX)
    |=> atten_code == $past(atten_code) + `APC_ATT_STEP;
  endproperty
  a_step_up: assert property (p_step_up)
    else $error("Increment pulse did not raise attenuation");

  property p_step_sat;
    @(posedge mclk_in) disable iff (rst_in)
    (att_mode == APC_ATT_STEPS && step_req && atten_code == `APC_ATT_MAX
      && !dec_pulse) |=> atten_code == `APC_ATT_MAX;
  endproperty
  a_step_sat: assert property (p_step_sat)
    else $error("Attenuation left maximum code");

  property p_step_start;
    @(posedge mclk_in) disable iff (rst_in)
    s_step_entry |=> atten_code == $past(attenuation_start_value);
  endproperty
  a_step_start: assert property (p_step_start)
    else $error("Step mode did not load start value");

  property p_readback;
    @(posedge mclk_in) disable iff (rst_in)
    (reg_rd_in && reg_addr_in == `APC_ADDR_ATT_RB)
    |=> reg_ack_out && reg_rdata_out == $past(atten_code);
  endproperty
  a_readback: assert property (p_readback)
    else $error("Attenuation readback mismatch");

  property p_gpio_drive;
    @(posedge mclk_in) disable iff (rst_in)
    (reg_wr_in && reg_addr_in == `APC_ADDR_GP_OUT)
    |=> gain_control_pins_out == $past(reg_wdata_in[`APC_NPIN-1:0]);
  endproperty
  a_gpio_drive: assert property (p_gpio_drive)
    else $error("GPIO output level not updated");

  property p_stby_enter;
    @(posedge mclk_in) disable iff (rst_in)
    s_pin_standby |-> ##[1:STBY_CYC] standby_out;
  endproperty
  a_stby_enter: assert property (p_stby_enter)
    else $error("Standby not reached in time");

  property p_stby_clocks;
    @(posedge mclk_in) disable iff (rst_in)
    standby_out |-> clocks_run_out && link_run_out && !sleep_out;
  endproperty
  a_stby_clocks: assert property (p_stby_clocks)
    else $error("Clocks or link stopped in standby");
endmodule

//--- tb/apc_host_model.sv
// Purpose: Host model that drives the gain-control pins
// Assumes: Pulse requests are one cycle wide, raised after a clock edge
// Notes: A pin the device enables carries the device level
`timescale 1ns/1ns
module apc_host_model (
  input wire logic mclk_in,
  input wire logic inc_go_in,
  input wire logic dec_go_in,
  input wire logic [3:0] level_in,
  input wire logic [3:0] dev_pins_in,
  input wire logic [3:0] dev_oe_n_in,
  output logic [3:0] pins_out
);
  logic [2:0] inc_cnt;
  logic [2:0] dec_cnt;
  logic [3:0] host_drv;
  initial begin
    inc_cnt = 3'h0;
    dec_cnt = 3'h0;
  end
  // ====================================================================
  // Pulse timing
  // three cycles high then three low
  always @(posedge mclk_in) begin
    if (inc_go_in) begin
      inc_cnt <= 3'h6;
    end else if (inc_cnt != 3'h0) begin
      inc_cnt <= inc_cnt - 3'h1;
    end
    if (dec_go_in) begin
      dec_cnt <= 3'h6;
    end else if (dec_cnt != 3'h0) begin
      dec_cnt <= dec_cnt - 3'h1;
    end
  end
  // ====================================================================
  // Wire resolution
  assign host_drv = {level_in[3:2], level_in[1] | (dec_cnt > 3'h3),
                     level_in[0] | (inc_cnt > 3'h3)};
  assign pins_out = (host_drv & dev_oe_n_in) | (dev_pins_in & ~dev_oe_n_in);
endmodule

//--- tb/apc_top_tb.sv
// Purpose: Self-checking bench for the gain-control pin block
// Assumes: Register strobes are one-cycle pulses, ack one cycle later
// Notes: Random values from a fixed seed
`timescale 1ns/1ns
`include "apc_defines.svh"
module apc_top_tb;
  logic mclk_in, rst_in, wr, rd, ack, inc_go, dec_go;
  logic [8:0] addr;
  logic [7:0] wdata, rdata, atten, blk_pd, a, b, s, d, o, e;
  logic [3:0] pins_w, pins_o, oe_n, level;
  logic sleep, stby, clk_run, link_run, nvg, up;
  int n_fail = 0;
  int n_compared = 0;
  int cnt, seed;
  apc_top i_apc_top (.mclk_in(mclk_in), .rst_in(rst_in),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_ack_out(ack),
    .gain_control_pins_in(pins_w), .gain_control_pins_out(pins_o),
    .gain_control_pins_oe_n_out(oe_n), .atten_code_out(atten),
    .sleep_out(sleep), .standby_out(stby), .block_pd_out(blk_pd),
    .clocks_run_out(clk_run), .link_run_out(link_run),
    .neg_voltage_gen_standby_out(nvg));
  apc_host_model i_apc_host_model (.mclk_in(mclk_in), .inc_go_in(inc_go),
    .dec_go_in(dec_go), .level_in(level), .dev_pins_in(pins_o),
    .dev_oe_n_in(oe_n), .pins_out(pins_w));
  // ====================================================================
  // Helpers
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic bus(input logic w, input logic [8:0] ad,
                     input logic [7:0] dt);
    @(posedge mclk_in);
    #1;
    addr = ad;
    wdata = dt;
    wr = w;
    rd = !w;
    @(posedge mclk_in);
    #1;
    wr = 1'b0;
    rd = 1'b0;
    chk("ack", {7'h0, ack}, 8'h01);
  endtask
  task automatic rdc(input logic [8:0] ad, input logic [7:0] exp);
    bus(1'b0, ad, 8'h00);
    chk($sformatf("reg %h", ad), rdata, exp);
  endtask
  task automatic pulse(input logic u);
    @(posedge mclk_in);
    #1;
    inc_go = u;
    dec_go = !u;
    wait_n(1);
    inc_go = 1'b0;
    dec_go = 1'b0;
    wait_n(9);
  endtask
  function automatic logic [7:0] step_exp(input logic [7:0] c,
                                          input logic u);
    if (u) begin
      return (c == `APC_ATT_MAX) ? c : c + `APC_ATT_STEP;
    end
    return (c == `APC_ATT_MIN) ? c : c - `APC_ATT_STEP;
  endfunction
  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ====================================================================
  // Clock and watchdog
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
  // ====================================================================
  // Scenarios
  initial begin
    seed = $urandom(40);
    {rst_in, wr, rd, inc_go, dec_go} = 5'b10000;
    addr = 9'h000;
    wdata = 8'h00;
    level = 4'h0;
    repeat (4) @(posedge mclk_in);
    #1 rst_in = 1'b0;
    rdc(9'h002, 8'h00);
    rdc(9'h180, 8'h00);
    rdc(9'h181, 8'h0c);
    rdc(9'h182, 8'h0c);
    rdc(9'h184, 8'h0c);
    level[1] = 1'b1;
    wait_n(4);
    chk("atten", atten, 8'h0c);
    for (int k = 0; k < 4; k++) begin
      a = $urandom;
      b = $urandom;
      bus(1'b1, 9'h181, a);
      bus(1'b1, 9'h182, b);
      level[1] = k[0];
      wait_n(4);
      chk("atten", atten, k[0] ? b : a);
      rdc(9'h184, k[0] ? b : a);
    end
    bus(1'b1, 9'h184, ~atten);
    rdc(9'h184, b);
    rdc(9'h1ff, 8'h00);
    level = 4'h0;
    for (int k = 0; k < 3; k++) begin
      e = (k == 0) ? 8'h00 : (k == 1) ? 8'h1b : 8'($urandom_range(0, 27));
      bus(1'b1, 9'h180, 8'h00);
      bus(1'b1, 9'h183, e);
      bus(1'b1, 9'h180, 8'h01);
      wait_n(2);
      chk("start", atten, e);
      for (int j = 0; j < 12; j++) begin
        up = (j == 0) ? (k == 1) : 1'($urandom_range(0, 1));
        pulse(up);
        e = step_exp(e, up);
        chk("step", atten, e);
      end
      rdc(9'h184, e);
    end
    bus(1'b1, 9'h180, 8'h00);
    for (int k = 0; k < 4; k++) begin
      {s, d, o} = {$urandom, $urandom, $urandom};
      level = 4'($urandom);
      bus(1'b1, 9'h1b0, s);
      bus(1'b1, 9'h1b1, d);
      bus(1'b1, 9'h1b2, o);
      wait_n(3);
      chk("oe_n", {4'h0, oe_n}, {4'h0, ~(s[3:0] & d[3:0])});
      chk("pins", {4'h0, pins_o}, o & 8'h0f);
      rdc(9'h1b0, s & 8'h0f);
      rdc(9'h1b3, o & s & d & 8'h0f);
      rdc(9'h1b4, {4'h0, level} & s & ~d & 8'h0f);
    end
    bus(1'b1, 9'h1b0, 8'h00);
    level = 4'h0;
    for (int r = 0; r < 2; r++) begin
      b = $urandom;
      b[6] = r[0];
      bus(1'b1, 9'h150, b);
      for (int pm = 0; pm < 4; pm++) begin
        bus(1'b1, 9'h002, 8'(pm));
        wait_n(1);
        chk("power", {3'h0, sleep, stby, clk_run, link_run, nvg},
          {3'h0, pm == 1, pm == 2, pm != 1, pm != 1,
          pm == 2 && b[6]});
        chk("blk_pd", blk_pd, (pm == 1) ? 8'hff : (pm == 2) ? b : 8'h00);
      end
    end
    bus(1'b1, 9'h002, 8'h00);
    bus(1'b1, 9'h152, 8'h05);
    @(posedge mclk_in);
    #1 level[2] = 1'b1;
    cnt = 0;
    while (stby !== 1'b1 && cnt < 20) begin
      wait_n(1);
      cnt++;
    end
    chk("pin_stby", {7'h0, stby}, 8'h01);
    chk("stby_time", {7'h0, cnt <= 10}, 8'h01);
    level[2] = 1'b0;
    wait_n(4);
    chk("pin_wake", {7'h0, stby}, 8'h00);
    wait_n(250);
    chk("settled", {7'h0, stby}, 8'h00);
    close_out();
  end
endmodule
